// ===== include/pirq_pkg.sv
// package for the port input interrupt flag and dma request block
package pirq_pkg;
    // ==================================================
    // register indices (printed offsets), byte address = 4 * index
    localparam logic [19:0] IDX_ROUTE_LO   = 20'h40290;
    localparam logic [19:0] IDX_ROUTE_HI   = 20'h40293;
    localparam logic [19:0] IDX_DMAEN_LO   = 20'h40294;
    localparam logic [19:0] IDX_DMAEN_HI   = 20'h40297;
    localparam logic [19:0] IDX_FLAG       = 20'h40280;
    localparam logic [19:0] IDX_INTEN      = 20'h40270;
    localparam logic [19:0] IDX_PRIO_LO    = 20'h40260;
    localparam logic [19:0] IDX_PRIO_HI    = 20'h40261;
    localparam logic [19:0] IDX_TRIG_TYPE  = 20'h402c9;
    localparam logic [19:0] IDX_TRIG_POL   = 20'h402c8;
    localparam logic [19:0] IDX_CONTROL    = 20'h402d0;
    // ==================================================
    // field positions and reset values
    localparam int          CTL_METHOD_BIT = 0;
    localparam int          NUM_CH         = 10;
    localparam logic [7:0]  RST_BYTE       = 8'h00;
    localparam logic [0:0]  RST_METHOD     = 1'h1;
    // ==================================================
    // cpu side state
    typedef struct packed {
        logic       global_int_enable;
        logic [2:0] current_level;
    } pirq_cpu_t;
endpackage

// ===== hw/pirq_core.sv
// port input interrupt flags, cpu request and dma request logic
//
// Overview of operation
// - a flag reads one once its condition occurred since the last clear.
// - clear-only method: writing one clears a flag, zero leaves it.
// - read/write method: writing one sets a flag, zero clears it.
// - method select bit one means clear-only, zero read/write; clear-only at reset.
// - flags set on trigger regardless of enable and priority.
// - cpu request needs enable, top priority, global enable, level above cpu level.
// - dma routed channel requests cpu only after dma transfer completes.
// - flags clear only by software writes.
// - flags undefined after reset; software clears them before enabling.
// - route bits: set-only or read/write method, readable.
// - route bit one invokes dma, zero normal interrupt; resets to zero.
// - dma enable bit gates dma request, same write semantics, resets zero.
// - route bits for channels 3-0 and 7-4 in two registers.
// - dma enable bits for channels 3-0 and 7-4 in two registers.
// - detection runs only while the prescaler clock runs.
// - in deep halt or sleep, edge setting wakes by level.
// - falling wake with pin already low resumes at once.
// - trigger type one edge, zero level; level at cold start, kept at hot.
// - polarity one high or rising, zero low or falling; kept at hot start.
// - interrupt enable bits gate cpu request, reset to zero.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pirq_core #(
    parameter int NCH = 10
) (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  cold_start,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [21:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // inputs: 8 port channels then 2 key groups
    input  wire logic [NCH-1:0]        chan_in,
    input  wire logic                  prescaler_run,
    input  wire logic                  low_power,
    input  wire pirq_pkg::pirq_cpu_t   cpu_state,
    // dma side
    output logic      [7:0]            dma_req,
    input  wire logic [7:0]            dma_done,
    // cpu side
    output logic                       cpu_irq,
    output logic      [3:0]            cpu_irq_chan,
    output logic      [2:0]            cpu_irq_level,
    output logic                       cpu_wake
);
    // ==================================================
    // register state
    logic [NCH-1:0] flag_r;
    logic [NCH-1:0] inten_r;
    logic [7:0]     route_r;
    logic [7:0]     dmaen_r;
    logic [NCH-1:0] ttype_r;
    logic [NCH-1:0] tpol_r;
    logic [2:0]     prio_r [NCH];
    logic           method_r;
    logic [7:0]     dma_pend_r;
    logic [NCH-1:0] irq_ok_r;
    logic [NCH-1:0] s1_r, s2_r, s3_r;
    logic           init_r;

    // ==================================================
    // apb decode: zero wait states, unmapped answers pslverr
    logic [19:0] idx;
    logic        wr_en;
    logic        hit;
    assign idx     = paddr[21:2];
    assign wr_en   = psel && penable && pwrite;
    assign pready  = 1'b1;
    // hit comes from the read decode below
    assign pslverr = psel && penable && !hit;

    logic w_route_lo, w_route_hi, w_dmaen_lo, w_dmaen_hi, w_flag, w_inten;
    logic w_prio_lo, w_prio_hi, w_ttype, w_tpol, w_ctl;
    assign w_route_lo = wr_en && idx == pirq_pkg::IDX_ROUTE_LO;
    assign w_route_hi = wr_en && idx == pirq_pkg::IDX_ROUTE_HI;
    assign w_dmaen_lo = wr_en && idx == pirq_pkg::IDX_DMAEN_LO;
    assign w_dmaen_hi = wr_en && idx == pirq_pkg::IDX_DMAEN_HI;
    assign w_flag     = wr_en && idx == pirq_pkg::IDX_FLAG;
    assign w_inten    = wr_en && idx == pirq_pkg::IDX_INTEN;
    assign w_prio_lo  = wr_en && idx == pirq_pkg::IDX_PRIO_LO;
    assign w_prio_hi  = wr_en && idx == pirq_pkg::IDX_PRIO_HI;
    assign w_ttype    = wr_en && idx == pirq_pkg::IDX_TRIG_TYPE;
    assign w_tpol     = wr_en && idx == pirq_pkg::IDX_TRIG_POL;
    assign w_ctl      = wr_en && idx == pirq_pkg::IDX_CONTROL;

    // ==================================================
    // read mux, registered data
    logic [31:0] rd_nxt;
    always_comb begin
        rd_nxt = 32'h0;
        hit = 1'b1;
        if (idx == pirq_pkg::IDX_ROUTE_LO) begin
            rd_nxt[3:0] = route_r[3:0];
        end else if (idx == pirq_pkg::IDX_ROUTE_HI) begin
            rd_nxt[7:4] = route_r[7:4];
        end else if (idx == pirq_pkg::IDX_DMAEN_LO) begin
            rd_nxt[3:0] = dmaen_r[3:0];
        end else if (idx == pirq_pkg::IDX_DMAEN_HI) begin
            rd_nxt[7:4] = dmaen_r[7:4];
        end else if (idx == pirq_pkg::IDX_FLAG) begin
            rd_nxt[NCH-1:0] = flag_r;
        end else if (idx == pirq_pkg::IDX_INTEN) begin
            rd_nxt[NCH-1:0] = inten_r;
        end else if (idx == pirq_pkg::IDX_PRIO_LO) begin
            for (int i = 0; i < 5; i++) begin
                rd_nxt[4*i +: 3] = prio_r[i];
            end
        end else if (idx == pirq_pkg::IDX_PRIO_HI) begin
            for (int i = 0; i < 5; i++) begin
                rd_nxt[4*i +: 3] = prio_r[i+5];
            end
        end else if (idx == pirq_pkg::IDX_TRIG_TYPE) begin
            rd_nxt[NCH-1:0] = ttype_r;
        end else if (idx == pirq_pkg::IDX_TRIG_POL) begin
            rd_nxt[NCH-1:0] = tpol_r;
        end else if (idx == pirq_pkg::IDX_CONTROL) begin
            rd_nxt[pirq_pkg::CTL_METHOD_BIT] = method_r;
        end else begin
            hit = 1'b0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_nxt;
        end
    end

    // ==================================================
    // control bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            method_r <= pirq_pkg::RST_METHOD;
        end else if (w_ctl) begin
            method_r <= pwdata[pirq_pkg::CTL_METHOD_BIT];
        end
    end

    // route and dma enable: set-only or read/write
    function automatic logic [7:0] upd8(input logic [7:0] old, input logic [7:0] wd,
                                        input logic [7:0] m, input logic so);
        upd8 = so ? (old | (wd & m)) : ((old & ~m) | (wd & m));
    endfunction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_r <= pirq_pkg::RST_BYTE;
            dmaen_r <= pirq_pkg::RST_BYTE;
        end else begin
            if (w_route_lo) route_r <= upd8(route_r, pwdata[7:0], 8'h0f, method_r);
            if (w_route_hi) route_r <= upd8(route_r, pwdata[7:0], 8'hf0, method_r);
            if (w_dmaen_lo) dmaen_r <= upd8(dmaen_r, pwdata[7:0], 8'h0f, method_r);
            if (w_dmaen_hi) dmaen_r <= upd8(dmaen_r, pwdata[7:0], 8'hf0, method_r);
        end
    end

    // enable resets; priority has no defined reset value but gets zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inten_r <= '0;
            for (int i = 0; i < NCH; i++) prio_r[i] <= 3'h0;
        end else begin
            if (w_inten) inten_r <= pwdata[NCH-1:0];
            for (int i = 0; i < 5; i++) begin
                if (w_prio_lo && i < NCH) prio_r[i] <= pwdata[4*i +: 3];
                if (w_prio_hi && i + 5 < NCH) prio_r[i+5] <= pwdata[4*i +: 3];
            end
        end
    end

    // trigger settings survive a hot start, so they are loaded after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_r <= 1'b1;
        end else begin
            init_r <= 1'b0;
        end
    end
    always_ff @(posedge pclk) begin
        if (init_r && cold_start) begin
            ttype_r <= '0;
            tpol_r  <= '0;
        end else begin
            if (w_ttype) ttype_r <= pwdata[NCH-1:0];
            if (w_tpol) tpol_r <= pwdata[NCH-1:0];
        end
    end

    // ==================================================
    // pin sync and detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= chan_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    // a value counts once stages two and three agree; one-cycle glitches drop out
    logic [NCH-1:0] agree;
    logic [NCH-1:0] pin_r;
    logic [NCH-1:0] lvl;
    logic [NCH-1:0] trig;
    assign agree = ~(s2_r ^ s3_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_r <= '0;
        end else begin
            pin_r <= (agree & s3_r) | (~agree & pin_r);
        end
    end

    generate
        for (genvar g = 0; g < NCH; g++) begin : g_det
            assign lvl[g]  = tpol_r[g] ? pin_r[g] : !pin_r[g];
            assign trig[g] = prescaler_run && (ttype_r[g] ?
                             (agree[g] && s3_r[g] != pin_r[g] && s3_r[g] == tpol_r[g]) :
                             lvl[g]);
        end
    endgenerate

    // ==================================================
    // flags: no reset, undefined until software clears them
    logic [NCH-1:0] fmask;
    assign fmask = pwdata[NCH-1:0];
    always_ff @(posedge pclk) begin
        for (int i = 0; i < NCH; i++) begin
            if (trig[i]) begin
                flag_r[i] <= 1'b1;
            end else if (w_flag) begin
                if (method_r) begin
                    if (fmask[i]) flag_r[i] <= 1'b0;
                end else begin
                    flag_r[i] <= fmask[i];
                end
            end
        end
    end

    // ==================================================
    // dma request and completion gating
    logic [7:0] dma_on;
    assign dma_on = route_r & dmaen_r;
    logic [7:0] flag_rise;
    logic [NCH-1:0] flag_d_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_d_r <= '0;
        end else begin
            flag_d_r <= flag_r;
        end
    end
    assign flag_rise = flag_r[7:0] & ~flag_d_r[7:0];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_pend_r <= 8'h00;
            irq_ok_r   <= '0;
        end else begin
            irq_ok_r[NCH-1:8] <= '1;
            for (int i = 0; i < 8; i++) begin
                if (route_r[i]) begin
                    if (dma_done[i] && dma_pend_r[i]) irq_ok_r[i] <= 1'b1;
                    else if (flag_rise[i]) irq_ok_r[i] <= 1'b0;
                end else begin
                    irq_ok_r[i] <= 1'b1;
                end
            end
            for (int i = 0; i < 8; i++) begin
                if (flag_rise[i] && dma_on[i]) dma_pend_r[i] <= 1'b1;
                else if (dma_done[i]) dma_pend_r[i] <= 1'b0;
            end
        end
    end
    assign dma_req = dma_pend_r;

    logic [NCH-1:0] irq_en;
    assign irq_en = irq_ok_r & ~NCH'(route_r & flag_rise);

    // ==================================================
    // cpu request: highest priority candidate, lowest channel on tie
    logic [3:0] best;
    logic [2:0] best_lvl;
    logic       any;
    always_comb begin
        best = 4'h0;
        best_lvl = 3'h0;
        any = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            if (flag_r[i] && inten_r[i] && irq_en[i] &&
                (!any || prio_r[i] > best_lvl)) begin
                any = 1'b1;
                best = 4'(i);
                best_lvl = prio_r[i];
            end
        end
    end
    // a flag left set re-requests after reti
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_irq       <= 1'b0;
            cpu_irq_chan  <= 4'h0;
            cpu_irq_level <= 3'h0;
        end else begin
            cpu_irq <= any && cpu_state.global_int_enable &&
                       best_lvl > cpu_state.current_level;
            cpu_irq_chan  <= best;
            cpu_irq_level <= best_lvl;
        end
    end

    // wake by level even for edge settings; a pin already low wakes at once
    logic [NCH-1:0] wake_src;
    assign wake_src = lvl & inten_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_wake <= 1'b0;
        end else begin
            cpu_wake <= low_power && |wake_src;
        end
    end

    // ==================================================
    // assertions
    AST_IRQ_NEEDS_GIE: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_irq |-> $past(cpu_state.global_int_enable))
        else $error("irq without global enable");
    AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_irq |-> cpu_irq_level > $past(cpu_state.current_level))
        else $error("irq level not above cpu level");
    AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
        trig[0] && w_flag |=> flag_r[0])
        else $error("set lost against clear");
    AST_CLR_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
        w_flag && method_r && !pwdata[1] && flag_r[1] |=> flag_r[1])
        else $error("zero write changed flag");
    AST_RW_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        w_flag && !method_r && !pwdata[2] && !trig[2] |=> !flag_r[2])
        else $error("read write clear failed");
    AST_NO_AUTO_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        flag_r[0] && !w_flag |=> flag_r[0])
        else $error("flag cleared without write");
    AST_ROUTE_SETONLY: assert property (@(posedge pclk) disable iff (!presetn)
        w_route_lo && method_r && route_r[0] |=> route_r[0])
        else $error("route bit cleared in set only");
    AST_DMA_GATED: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(dma_req[6]) |-> $past(dmaen_r[6] && route_r[6]))
        else $error("dma request while disabled");
    AST_DMA_NO_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        route_r[6] && (flag_rise[6] || dma_pend_r[6]) |=> !(cpu_irq && cpu_irq_chan == 4'h6))
        else $error("routed channel requested cpu");
    AST_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
        low_power && |wake_src |=> cpu_wake)
        else $error("no wake");
endmodule
`default_nettype wire

// ===== sim/pirq_dma_model.sv
// dma controller model answering the port channel requests
`timescale 1ns/1ps
`default_nettype none
module pirq_dma_model (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // requests, stall length and completions
    input  wire logic [7:0] dma_req,
    input  wire logic [7:0] stall,
    output logic      [7:0] dma_done
);
    // ==========
    // per channel: 0 idle, 1 transferring, 2 waiting for the request to drop
    logic [1:0] st_r  [8];
    logic [7:0] cnt_r [8];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_done <= 8'h00;
            st_r     <= '{default: 2'h0};
            cnt_r    <= '{default: 8'h00};
        end else begin
            for (int i = 0; i < 8; i++) begin
                dma_done[i] <= 1'b0;
                if (st_r[i] == 2'h0 && dma_req[i]) begin
                    st_r[i]  <= 2'h1;
                    cnt_r[i] <= stall;
                end else if (st_r[i] == 2'h1 && cnt_r[i] != 8'h00) begin
                    cnt_r[i] <= cnt_r[i] - 8'h01;
                end else if (st_r[i] == 2'h1) begin
                    // one pulse per transfer; the request is still high for an edge after it
                    dma_done[i] <= 1'b1;
                    st_r[i]     <= 2'h2;
                end else if (st_r[i] == 2'h2 && !dma_req[i]) begin
                    st_r[i] <= 2'h0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench for the port input interrupt flag and dma request block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ==========
    // connections and bench state
    logic                pclk, presetn, cold_start, psel, penable, pwrite;
    logic [21:0]         paddr;
    logic [31:0]         pwdata, prdata;
    logic                pready, pslverr, prescaler_run, low_power;
    logic [9:0]          chan_in;
    pirq_pkg::pirq_cpu_t cpu_state;
    logic [7:0]          dma_req, dma_done, stall, fl, en;
    logic                cpu_irq, cpu_wake, rerr;
    logic [3:0]          cpu_irq_chan;
    logic [2:0]          cpu_irq_level;
    logic [31:0]         rdat, d;
    logic [39:0]         pr;
    logic [19:0]         rsel [4];
    logic [31:0]         rmsk [4];
    int                  miscompares = 0;
    int                  comparisons = 0;
    int                  cycles = 0;

    pirq_core #(.NCH(10)) i_pirq_core (
        .pclk(pclk), .presetn(presetn), .cold_start(cold_start), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .chan_in(chan_in),
        .prescaler_run(prescaler_run), .low_power(low_power), .cpu_state(cpu_state),
        .dma_req(dma_req), .dma_done(dma_done), .cpu_irq(cpu_irq),
        .cpu_irq_chan(cpu_irq_chan), .cpu_irq_level(cpu_irq_level), .cpu_wake(cpu_wake)
    );
    pirq_dma_model i_pirq_dma_model (
        .pclk(pclk), .presetn(presetn), .dma_req(dma_req), .stall(stall),
        .dma_done(dma_done)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // generous ceiling: the sequence needs little more than a thousand cycles
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end

    // ==========
    // tasks and expectation functions
    task automatic report_and_stop();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // zero-wait slave, but the master still waits for pready
    task automatic apb(input logic wr, input logic [19:0] idx, input logic [31:0] wd);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [19:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd);
    endtask

    task automatic chk_reg(input logic [19:0] idx, input logic [31:0] e,
                           input logic [31:0] m = 32'hffff_ffff);
        apb(1'b0, idx, 32'h0);
        chk32(rdat & m, e, "register read");
    endtask

    // expected {request, channel, level}; equal priority goes to the lowest channel
    function automatic logic [7:0] pick(input logic [7:0] f, input logic [7:0] e,
                                        input logic [39:0] p, input pirq_pkg::pirq_cpu_t c);
        logic [3:0] best;
        logic [2:0] lv;
        logic       hit;
        hit = 1'b0;
        best = 4'h0;
        lv = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (f[i] && e[i] && (!hit || p[4*i +: 3] > lv)) begin
                hit = 1'b1;
                best = 4'(i);
                lv = p[4*i +: 3];
            end
        end
        hit = hit && c.global_int_enable && (lv > c.current_level);
        return {hit, best, lv};
    endfunction

    task automatic chk_irq(input logic [7:0] e);
        chk32({24'h0, cpu_irq, e[7] ? {cpu_irq_chan, cpu_irq_level} : 7'h0},
              {24'h0, e[7] ? e : 8'h00}, "cpu request");
    endtask

    task automatic do_reset(input logic cold);
        cold_start <= cold;
        presetn    <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask

    // ==========
    // main sequence
    initial begin
        void'($urandom(44874));
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {chan_in, low_power, cpu_state, stall} = '0;
        {presetn, cold_start, prescaler_run} = 3'b011;
        rsel = '{pirq_pkg::IDX_ROUTE_LO, pirq_pkg::IDX_ROUTE_HI,
                 pirq_pkg::IDX_DMAEN_LO, pirq_pkg::IDX_DMAEN_HI};
        rmsk = '{32'h0f, 32'hf0, 32'h0f, 32'hf0};
        do_reset(1'b1);
        for (int j = 0; j < 4; j++) chk_reg(rsel[j], 32'h0);
        chk_reg(pirq_pkg::IDX_INTEN, 32'h0);
        chk_reg(pirq_pkg::IDX_TRIG_TYPE, 32'h0);
        chk_reg(pirq_pkg::IDX_TRIG_POL, 32'h0);
        chk_reg(pirq_pkg::IDX_CONTROL, 32'h1);
        apb(1'b0, 20'h40300, 32'h0);
        chk32({rdat[30:0], rerr}, 32'h1, "unmapped read");
        // level, high active; flags start undefined so clear them first
        wr(pirq_pkg::IDX_TRIG_POL, 32'hff);
        repeat (6) @(posedge pclk);
        wr(pirq_pkg::IDX_FLAG, 32'h3ff);
        chk_reg(pirq_pkg::IDX_FLAG, 32'h0, 32'hff);
        for (int c = 0; c < 8; c++) begin
            chan_in <= 10'h1 << c;
            repeat (2 + $urandom % 3) @(posedge pclk);
            chan_in <= 10'h000;
            repeat (6) @(posedge pclk);
            chk_reg(pirq_pkg::IDX_FLAG, 32'h1 << c, 32'hff);
            wr(pirq_pkg::IDX_FLAG, 32'h0);
            chk_reg(pirq_pkg::IDX_FLAG, 32'h1 << c, 32'hff);
            wr(pirq_pkg::IDX_FLAG, 32'h1 << c);
            chk_reg(pirq_pkg::IDX_FLAG, 32'h0, 32'hff);
        end
        chan_in <= 10'h001;
        repeat (6) @(posedge pclk);
        wr(pirq_pkg::IDX_FLAG, 32'h1);
        chk_reg(pirq_pkg::IDX_FLAG, 32'h1, 32'hff);
        chan_in <= 10'h000;
        repeat (6) @(posedge pclk);
        wr(pirq_pkg::IDX_FLAG, 32'h1);
        prescaler_run <= 1'b0;
        chan_in <= 10'h010;
        repeat (6) @(posedge pclk);
        chan_in <= 10'h000;
        repeat (6) @(posedge pclk);
        prescaler_run <= 1'b1;
        repeat (6) @(posedge pclk);
        chk_reg(pirq_pkg::IDX_FLAG, 32'h0, 32'hff);
        // edge trigger, falling then rising
        chan_in <= 10'h0ff;
        wr(pirq_pkg::IDX_TRIG_TYPE, 32'hff);
        wr(pirq_pkg::IDX_TRIG_POL, 32'h00);
        wr(pirq_pkg::IDX_FLAG, 32'hff);
        chan_in <= 10'h0f7;
        repeat (6) @(posedge pclk);
        chk_reg(pirq_pkg::IDX_FLAG, 32'h08, 32'hff);
        wr(pirq_pkg::IDX_FLAG, 32'h08);
        chk_reg(pirq_pkg::IDX_FLAG, 32'h00, 32'hff);
        wr(pirq_pkg::IDX_TRIG_POL, 32'hff);
        wr(pirq_pkg::IDX_FLAG, 32'hff);
        chan_in <= 10'h0ff;
        repeat (6) @(posedge pclk);
        chk_reg(pirq_pkg::IDX_FLAG, 32'h08, 32'hff);
        // read/write method, then set-only on route and dma enable
        wr(pirq_pkg::IDX_CONTROL, 32'h0);
        chk_reg(pirq_pkg::IDX_CONTROL, 32'h0);
        for (int n = 0; n < 12; n++) begin
            d = $urandom;
            wr(rsel[n % 4], d);
            chk_reg(rsel[n % 4], d & rmsk[n % 4]);
        end
        for (int j = 0; j < 4; j++) wr(rsel[j], 32'h0);
        wr(pirq_pkg::IDX_CONTROL, 32'h1);
        for (int j = 0; j < 4; j++) begin
            wr(rsel[j], 32'h55);
            wr(rsel[j], 32'h00);
            chk_reg(rsel[j], 32'h55 & rmsk[j]);
            wr(rsel[j], 32'haa);
            chk_reg(rsel[j], 32'hff & rmsk[j]);
        end
        wr(pirq_pkg::IDX_CONTROL, 32'h0);
        for (int j = 0; j < 4; j++) wr(rsel[j], 32'h0);
        // cpu request arbitration: two fixed corners, then random
        for (int n = 0; n < 24; n++) begin
            fl = 8'($urandom);
            en = 8'($urandom);
            pr = {8'($urandom), 32'($urandom)};
            if (n < 2) begin
                fl = 8'h24;
                en = 8'hff;
                pr = 40'h00_0060_0600;
            end
            cpu_state <= (n < 2) ? {1'b1, 3'(5 + n)} : {($urandom % 4 != 0), 3'($urandom)};
            wr(pirq_pkg::IDX_FLAG, {24'h0, fl});
            wr(pirq_pkg::IDX_INTEN, {24'h0, en});
            wr(pirq_pkg::IDX_PRIO_LO, {12'h0, pr[19:0]});
            wr(pirq_pkg::IDX_PRIO_HI, {12'h0, pr[39:20]});
            repeat (2) @(posedge pclk);
            chk_irq(pick(fl, en, pr, cpu_state));
            chk_reg(pirq_pkg::IDX_FLAG, {24'h0, fl}, 32'hff);
        end
        // channel 6 served by dma, prompt then stalled transfers
        wr(pirq_pkg::IDX_FLAG, 32'h0);
        wr(pirq_pkg::IDX_INTEN, 32'hff);
        wr(pirq_pkg::IDX_PRIO_HI, 32'h50);
        wr(pirq_pkg::IDX_ROUTE_HI, 32'h40);
        wr(pirq_pkg::IDX_DMAEN_HI, 32'h40);
        cpu_state <= {1'b1, 3'h0};
        for (int n = 0; n < 3; n++) begin
            stall <= (n == 0) ? 8'h00 : 8'($urandom % 40);
            chan_in <= 10'h0bf;
            repeat (2) @(posedge pclk);
            chan_in <= 10'h0ff;
            repeat (6) @(posedge pclk);
            chk32({24'h0, dma_req}, 32'h40, "dma request");
            chk32({31'h0, cpu_irq}, 32'h0, "irq during transfer");
            for (int w = 0; w < 100 && dma_req[6] !== 1'b0; w++) @(posedge pclk);
            repeat (2) @(posedge pclk);
            chk_irq({1'b1, 4'h6, 3'h5});
            chk_reg(pirq_pkg::IDX_FLAG, 32'h40, 32'hff);
            wr(pirq_pkg::IDX_FLAG, 32'h0);
        end
        // wake from low power is by level even with edge triggering
        wr(pirq_pkg::IDX_INTEN, 32'h01);
        chan_in <= 10'h001;
        low_power <= 1'b1;
        repeat (6) @(posedge pclk);
        chk32({31'h0, cpu_wake}, 32'h1, "wake on high");
        wr(pirq_pkg::IDX_TRIG_POL, 32'h00);
        repeat (3) @(posedge pclk);
        chk32({31'h0, cpu_wake}, 32'h0, "asleep while high");
        chan_in <= 10'h000;
        repeat (6) @(posedge pclk);
        chk32({31'h0, cpu_wake}, 32'h1, "wake on low");
        low_power <= 1'b0;
        // hot start keeps trigger settings, cold start clears them
        wr(pirq_pkg::IDX_TRIG_TYPE, 32'h5a);
        wr(pirq_pkg::IDX_TRIG_POL, 32'ha5);
        do_reset(1'b0);
        chk_reg(pirq_pkg::IDX_TRIG_TYPE, 32'h5a);
        chk_reg(pirq_pkg::IDX_TRIG_POL, 32'ha5);
        chk_reg(pirq_pkg::IDX_ROUTE_HI, 32'h0);
        do_reset(1'b1);
        chk_reg(pirq_pkg::IDX_TRIG_TYPE, 32'h0);
        chk_reg(pirq_pkg::IDX_TRIG_POL, 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
